// file: verilog/masd_top.sv
// Program and data address decode, data memory and configuration capture.
// Assumes the core drives requests on aclk and program memory answers
// one cycle after an address is presented.
// Summary of operation
// - Program address is 24 bits, three sources
// - User space ends at 7FFFFFh, table excepted
// - Program location is lower and upper word
// - Program counter aligned, steps by two
// - Reset starts at zero, vectors below 000200h
// - Primary and alternate vector table regions
// - Copy four configuration words after reset
// - Configuration base depends on memory size
// - Data addresses are 16-bit byte addresses
// - Bit 15 selects memory or program window
// - Reads at 4000h-7FFFh return zero; above 7FFFh zero unless the program window is enabled
// - Low byte even, high byte odd
// - Post-increment adds one or two
// - Byte read selects lane onto low byte
// - Shared word decode, separate lane strobes
// - Odd word access raises address error
// - Misaligned read completes, write suppressed
// - Byte load keeps register high byte
// - Sign extend and zero extend operations
// - Near space reached by 13-bit field
// - Full 16-bit direct address for moves
// - Separate read and write address generators
// - Control bit gates program window
`timescale 1ns/1ps
module masd_top (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_awaddr,
  input  wire logic                s_awvalid,
  output logic                     s_awready,
  input  wire logic [31:0]         s_wdata,
  input  wire logic [3:0]          s_wstrb,
  input  wire logic                s_wvalid,
  output logic                     s_wready,
  output logic [1:0]               s_bresp,
  output logic                     s_bvalid,
  input  wire logic                s_bready,
  input  wire logic [7:0]          s_araddr,
  input  wire logic                s_arvalid,
  output logic                     s_arready,
  output logic [31:0]              s_rdata,
  output logic [1:0]               s_rresp,
  output logic                     s_rvalid,
  input  wire logic                s_rready,
  input  wire logic                mem_size_large,
  input  wire masd_pkg::masd_preq_t preq,
  input  wire logic [23:0]         pm_rdata,
  output logic [23:0]              prog_addr_q,
  output masd_pkg::masd_region_t   prog_region_q,
  output logic                     prog_fault_q,
  output logic                     core_hold_q,
  input  wire masd_pkg::masd_dreq_t rd_req,
  input  wire masd_pkg::masd_wop_t  wop,
  input  wire logic [15:0]         wreg_old,
  input  wire logic [15:0]         psv_rdata,
  input  wire masd_pkg::masd_dreq_t wr_req,
  input  wire logic [15:0]         wr_data,
  output logic                     rd_valid_q,
  output logic [15:0]              rd_data_q,
  output logic [15:0]              rd_ea_q,
  output logic [15:0]              rd_ptr_next_q,
  output logic                     psv_sel_q,
  output logic [15:0]              wr_ea_q,
  output logic [15:0]              wr_ptr_next_q,
  output logic                     wreg_we_q,
  output logic [15:0]              wreg_new_q,
  output logic                     addr_err_q
);
  // ==========================================================================
  // Address generators
  function automatic logic [15:0] agu_ea(input masd_pkg::masd_dreq_t r);
    unique case (r.mode)
      masd_pkg::AM_NEAR: agu_ea = {masd_pkg::NEAR_PAGE, r.lit[12:0]};
      masd_pkg::AM_FULL: agu_ea = r.lit;
      default:           agu_ea = r.ptr;
    endcase
  endfunction : agu_ea

  function automatic logic [15:0] agu_next(input masd_pkg::masd_dreq_t r);
    agu_next = r.ptr;
    if (r.mode == masd_pkg::AM_POSTINC)
      agu_next = r.ptr + (r.byte_op ? 16'h0001 : 16'h0002);
  endfunction : agu_next

  logic [15:0]  rd_ea;
  logic [15:0]  wr_ea;
  logic         rd_mis;
  logic         wr_mis;
  logic [1:0]   lane_we;
  logic [15:0]  mem_word;
  logic [15:0]  raw;
  logic [7:0]   sel_byte;
  logic [15:0]  ctrl_q;
  logic [7:0]   table_page_register_q;
  logic         err_q;
  logic         fault_q;
  masd_pkg::masd_cstate_t cstate_q;
  logic [1:0]   sync_cnt_q;
  logic [2:0]   idx_q;
  logic         size_q;
  logic         sz_meta_q;
  logic         sz_sync_q;
  logic [23:0]  cfg_q [4];
  logic [22:0]  pc_q;
  logic [23:0]  paddr_d;
  logic         pfault_d;

  assign rd_ea  = agu_ea(rd_req);
  assign wr_ea  = agu_ea(wr_req);
  assign rd_mis = rd_req.req & ~rd_req.byte_op & rd_ea[0];
  assign wr_mis = wr_req.req & ~wr_req.byte_op & wr_ea[0];

  // ==========================================================================
  // Data memory, one array per byte lane behind a shared word decode
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_lane
      logic [7:0] mem [masd_pkg::DMEM_WORDS];
      // Byte data always arrives on the low byte and is steered to its lane
      assign lane_we[i] = wr_req.req & ~wr_mis & (wr_ea[15:14] == masd_pkg::DMEM_PAGE)
                          & (~wr_req.byte_op | (wr_ea[0] == 1'(i)));
      always_ff @(posedge aclk)
      begin
        if (lane_we[i])
          mem[wr_ea[13:1]] <= wr_req.byte_op ? wr_data[7:0] : wr_data[8*i +: 8];
      end
      assign mem_word[8*i +: 8] = mem[rd_ea[13:1]];
    end
  endgenerate

  always_comb
  begin
    raw = 16'h0000;
    if (rd_ea[15] == 1'b0)
    begin
      if (rd_ea[14] == 1'b0)
        raw = mem_word;
    end
    else if (ctrl_q[masd_pkg::PSV_BIT])
      raw = psv_rdata;
    sel_byte = rd_ea[0] ? raw[15:8] : raw[7:0];
  end

  // ==========================================================================
  // Read path and working register merge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_valid_q    <= 1'b0;
      rd_data_q     <= 16'h0000;
      rd_ea_q       <= 16'h0000;
      rd_ptr_next_q <= 16'h0000;
      psv_sel_q     <= 1'b0;
    end
    else
    begin
      // A misaligned word read still completes; only the error is flagged
      rd_valid_q <= rd_req.req;
      if (rd_req.req)
      begin
        rd_data_q     <= rd_req.byte_op ? {8'h00, sel_byte} : raw;
        rd_ea_q       <= rd_ea;
        rd_ptr_next_q <= agu_next(rd_req);
        psv_sel_q     <= rd_ea[15] & ctrl_q[masd_pkg::PSV_BIT];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wreg_we_q  <= 1'b0;
      wreg_new_q <= 16'h0000;
    end
    else
    begin
      wreg_we_q <= 1'b0;
      unique case (wop)
        masd_pkg::WOP_BYTE:
        begin
          wreg_we_q  <= rd_req.req;
          wreg_new_q <= {wreg_old[15:8], sel_byte};
        end
        masd_pkg::WOP_WORD:
        begin
          wreg_we_q  <= rd_req.req;
          wreg_new_q <= raw;
        end
        masd_pkg::WOP_SE:
        begin
          wreg_we_q  <= 1'b1;
          wreg_new_q <= {{8{wreg_old[7]}}, wreg_old[7:0]};
        end
        masd_pkg::WOP_ZE:
        begin
          wreg_we_q  <= 1'b1;
          wreg_new_q <= {8'h00, wreg_old[7:0]};
        end
        masd_pkg::WOP_NONE: wreg_we_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ea_q       <= 16'h0000;
      wr_ptr_next_q <= 16'h0000;
      addr_err_q    <= 1'b0;
    end
    else
    begin
      if (wr_req.req)
      begin
        wr_ea_q       <= wr_ea;
        wr_ptr_next_q <= agu_next(wr_req);
      end
      // Flag appears together with the registered address it belongs to
      addr_err_q <= rd_mis | wr_mis;
    end
  end

  // ==========================================================================
  // Program counter and program address
  always_comb
  begin
    pfault_d = 1'b0;
    unique case (preq.src)
      masd_pkg::PS_TABLE: paddr_d = {table_page_register_q, preq.tbl_off};
      masd_pkg::PS_REMAP:
      begin
        paddr_d  = preq.remap_addr;
        pfault_d = preq.remap_addr[23];
      end
      default: paddr_d = {1'b0, pc_q};
    endcase
    if (cstate_q == masd_pkg::CS_READ)
    begin
      paddr_d  = (size_q ? masd_pkg::CFG_BASE_LRG : masd_pkg::CFG_BASE_SML)
                 + {20'h0_0000, idx_q[1:0], 1'b0};
      pfault_d = 1'b0;
    end
    if (pfault_d)
      paddr_d = {1'b0, paddr_d[22:0]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pc_q <= masd_pkg::PC_RESET;
    else if (cstate_q == masd_pkg::CS_DONE)
    begin
      if (preq.load)
        pc_q <= {preq.target[22:1], 1'b0};
      else if (preq.step)
        pc_q <= preq.dec ? pc_q - masd_pkg::PC_STEP : pc_q + masd_pkg::PC_STEP;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prog_addr_q   <= 24'h00_0000;
      prog_region_q <= masd_pkg::RG_RESET;
      prog_fault_q  <= 1'b0;
    end
    else
    begin
      prog_addr_q  <= paddr_d;
      prog_fault_q <= pfault_d;
      if (paddr_d <= masd_pkg::RESET_TGT + 24'h00_0001)
        prog_region_q <= masd_pkg::RG_RESET;
      else if (paddr_d < masd_pkg::IVT_ALT_LO && paddr_d >= masd_pkg::IVT_PRI_LO)
        prog_region_q <= masd_pkg::RG_IVT_PRI;
      else if (paddr_d <= masd_pkg::IVT_ALT_HI)
        prog_region_q <= masd_pkg::RG_IVT_ALT;
      else
        prog_region_q <= masd_pkg::RG_CODE;
    end
  end

  // ==========================================================================
  // Configuration capture after every reset
  always_ff @(posedge aclk)
  begin
    sz_meta_q <= mem_size_large;
    sz_sync_q <= sz_meta_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cstate_q    <= masd_pkg::CS_SYNC;
      sync_cnt_q  <= 2'h0;
      idx_q       <= 3'h0;
      size_q      <= 1'b0;
      core_hold_q <= 1'b1;
    end
    else
    begin
      unique case (cstate_q)
        masd_pkg::CS_SYNC:
        begin
          // Wait for the strap to pass the synchroniser before using it
          sync_cnt_q <= sync_cnt_q + 2'h1;
          if (sync_cnt_q == masd_pkg::SYNC_CYCLES)
          begin
            size_q   <= sz_sync_q;
            cstate_q <= masd_pkg::CS_READ;
          end
        end
        masd_pkg::CS_READ:
        begin
          idx_q <= idx_q + 3'h1;
          if (idx_q != 3'h0)
            cfg_q[idx_q[1:0] - 2'h1] <= pm_rdata;
          if (idx_q == masd_pkg::CFG_WORDS)
          begin
            cstate_q    <= masd_pkg::CS_DONE;
            core_hold_q <= 1'b0;
          end
        end
        masd_pkg::CS_DONE: core_hold_q <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;

  assign wr_fire = aw_full_q & w_full_q & ~s_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= masd_pkg::RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (aw_addr_q <= masd_pkg::OFS_CFG3 && aw_addr_q[1:0] == 2'h0)
                     ? masd_pkg::RESP_OKAY : masd_pkg::RESP_SLVERR;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= masd_pkg::CTRL_RST;
      table_page_register_q <= masd_pkg::TABLE_PAGE_REGISTER_RST;
      err_q    <= 1'b0;
      fault_q  <= 1'b0;
    end
    else
    begin
      if (wr_fire && aw_addr_q == masd_pkg::OFS_CTRL && w_strb_q[0])
        ctrl_q <= {12'h000, 1'b0, w_data_q[masd_pkg::PSV_BIT], 2'h0};
      if (wr_fire && aw_addr_q == masd_pkg::OFS_TABLE_PAGE_REGISTER && w_strb_q[0])
        table_page_register_q <= w_data_q[7:0];
      // Hardware set wins over a same-cycle clear
      err_q   <= (err_q & ~(wr_fire && aw_addr_q == masd_pkg::OFS_STAT && w_data_q[1]))
                 | addr_err_q;
      fault_q <= (fault_q & ~(wr_fire && aw_addr_q == masd_pkg::OFS_STAT && w_data_q[2]))
                 | prog_fault_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= masd_pkg::RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= masd_pkg::RESP_OKAY;
      s_rdata   <= 32'h0000_0000;
      if (s_araddr == masd_pkg::OFS_CTRL)
        s_rdata <= {16'h0000, ctrl_q};
      else if (s_araddr == masd_pkg::OFS_TABLE_PAGE_REGISTER)
        s_rdata <= {24'h00_0000, table_page_register_q};
      else if (s_araddr == masd_pkg::OFS_STAT)
        s_rdata <= {28'h000_0000, size_q, fault_q, err_q, cstate_q == masd_pkg::CS_DONE};
      else if (s_araddr >= masd_pkg::OFS_CFG0 && s_araddr <= masd_pkg::OFS_CFG3
               && s_araddr[1:0] == 2'h0)
        s_rdata <= {8'h00, cfg_q[s_araddr[3:2]]};
      else
        s_rresp <= masd_pkg::RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  a_pc_reset_zero: assert property (@(posedge aclk) $rose(aresetn) |-> pc_q == 23'h00_0000)
    else $error("pc not zero after reset");
  a_pc_step_two: assert property (@(posedge aclk) disable iff (!aresetn)
    (cstate_q == masd_pkg::CS_DONE && preq.step && !preq.load && !preq.dec)
    |=> pc_q == $past(pc_q) + 23'h00_0002)
    else $error("pc did not step by two");
  a_misalign_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_mis || wr_mis) |=> addr_err_q && (rd_ea_q[0] || wr_ea_q[0]))
    else $error("misaligned access not flagged");
  a_write_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mis |-> lane_we == 2'b00)
    else $error("misaligned write reached memory");
  a_zero_return: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_req.req && rd_ea[15:14] == 2'b01) |=> rd_data_q == 16'h0000)
    else $error("unimplemented read not zero");
  a_byte_low_lane: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_req.req && rd_req.byte_op) |=> rd_data_q[15:8] == 8'h00)
    else $error("byte read upper lane not clear");
  a_postinc_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_req.req && rd_req.byte_op && rd_req.mode == masd_pkg::AM_POSTINC)
    |=> rd_ptr_next_q == $past(rd_req.ptr) + 16'h0001)
    else $error("byte post-increment wrong");
  a_near_field: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_req.req && rd_req.mode == masd_pkg::AM_NEAR) |=> rd_ea_q[15:13] == 3'h0)
    else $error("near address outside near space");
  a_byte_load_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_req.req && wop == masd_pkg::WOP_BYTE) |=> wreg_we_q
    && wreg_new_q[15:8] == $past(wreg_old[15:8]))
    else $error("byte load changed high byte");
  a_cfg_copy_done: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> ##[1:10] cstate_q == masd_pkg::CS_DONE)
    else $error("configuration copy too slow");
  a_psv_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_req.req && rd_ea[15] && !ctrl_q[masd_pkg::PSV_BIT]) |=> rd_data_q == 16'h0000)
    else $error("window read while disabled");
endmodule : masd_top

// file: verilog/masd_pkg.sv
// Constants, enumerations and carriers for the memory address space decoder.
// Assumes a single core clock and a synchronous active-low reset.
package masd_pkg;
  // ==========================================================================
  // Program space
  localparam logic [22:0] PC_RESET      = 23'h00_0000;
  localparam logic [22:0] PC_STEP       = 23'h00_0002;
  localparam logic [23:0] RESET_TGT     = 24'h00_0002;
  localparam logic [23:0] IVT_PRI_LO    = 24'h00_0004;
  localparam logic [23:0] IVT_ALT_LO    = 24'h00_0100;
  localparam logic [23:0] IVT_ALT_HI    = 24'h00_01FF;
  localparam logic [23:0] VEC_END       = 24'h00_0200;
  localparam logic [23:0] CFG_BASE_SML  = 24'h00_57F8;
  localparam logic [23:0] CFG_BASE_LRG  = 24'h00_ABF8;
  localparam logic [2:0]  CFG_WORDS     = 3'h4;
  localparam logic [1:0]  SYNC_CYCLES   = 2'h2;
  // ==========================================================================
  // Data space
  localparam int          DMEM_WORDS    = 8192;
  localparam logic [1:0]  DMEM_PAGE     = 2'h0;
  localparam logic [2:0]  NEAR_PAGE     = 3'h0;
  localparam int          PSV_BIT       = 2;
  // ==========================================================================
  // Register bus
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_TABLE_PAGE_REGISTER    = 8'h04;
  localparam logic [7:0]  OFS_STAT      = 8'h08;
  localparam logic [7:0]  OFS_CFG0      = 8'h10;
  localparam logic [7:0]  OFS_CFG3      = 8'h1C;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [7:0]  TABLE_PAGE_REGISTER_RST    = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {AM_IND, AM_POSTINC, AM_NEAR, AM_FULL} masd_amode_t;
  typedef enum logic [1:0] {PS_EXEC, PS_TABLE, PS_REMAP} masd_psrc_t;
  typedef enum logic [2:0] {WOP_NONE, WOP_BYTE, WOP_WORD, WOP_SE, WOP_ZE} masd_wop_t;
  typedef enum logic [1:0] {RG_RESET, RG_IVT_PRI, RG_IVT_ALT, RG_CODE} masd_region_t;
  typedef enum logic [1:0] {CS_SYNC, CS_READ, CS_DONE} masd_cstate_t;

  typedef struct packed {
    logic        req;
    logic        byte_op;
    masd_amode_t mode;
    logic [15:0] ptr;
    logic [15:0] lit;
  } masd_dreq_t;

  typedef struct packed {
    logic        step;
    logic        dec;
    logic        load;
    logic [22:0] target;
    masd_psrc_t  src;
    logic [15:0] tbl_off;
    logic [23:0] remap_addr;
  } masd_preq_t;
endpackage : masd_pkg

// file: testbench/masd_pmem_model.sv
// Program memory model on the far side of the fetch path.
// Assumes data comes one cycle after the address, as the core sees it.
`timescale 1ns/1ps
module masd_pmem_model (
  input  wire logic        aclk,
  input  wire logic [23:0] addr,
  output logic [23:0]      rdata
);
  // ==========================================================
  // Read path
  // Address folded into data so a wrong fetch address shows
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[7:0] ^ 8'hc3, a[15:0] ^ 16'h5a5a};
  endfunction : word_at

  // Combinational: the address is already a flop, the decoder reads a cycle later
  always_comb
  begin
    rdata = word_at(addr);
  end
endmodule : masd_pmem_model

// file: testbench/tb_memory_address_space_decoder.sv
// Self-checking bench for the address space decoder.
// Assumes masd_pkg and the program memory model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_memory_address_space_decoder;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_size_large;
  logic        prog_fault_q, core_hold_q, rd_valid_q, psv_sel_q, wreg_we_q, addr_err_q;
  logic [7:0]  s_awaddr, s_araddr;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [31:0] s_wdata, s_rdata, rd, seed;
  logic [23:0] pm_rdata, prog_addr_q;
  logic [15:0] wreg_old, psv_rdata, wr_data, rd_data_q, rd_ea_q, rd_ptr_next_q;
  logic [15:0] wr_ea_q, wr_ptr_next_q, wreg_new_q, w, ea;
  logic [15:0] dm [int];
  int          err_total, compares;
  masd_pkg::masd_preq_t   preq, pq;
  masd_pkg::masd_dreq_t   rd_req, wr_req;
  masd_pkg::masd_wop_t    wop;
  masd_pkg::masd_region_t prog_region_q;
  localparam masd_pkg::masd_dreq_t NOQ = '0;
  logic [22:0] tg [5] = '{23'h00_0003, 23'h00_00fe, 23'h00_0101, 23'h00_01fe, 23'h00_0200};
  masd_pkg::masd_region_t rg [5] = '{masd_pkg::RG_RESET, masd_pkg::RG_IVT_PRI,
    masd_pkg::RG_IVT_ALT, masd_pkg::RG_IVT_ALT, masd_pkg::RG_CODE};

  masd_top i_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .mem_size_large, .preq, .pm_rdata, .prog_addr_q,
    .prog_region_q, .prog_fault_q, .core_hold_q, .rd_req, .wop, .wreg_old, .psv_rdata,
    .wr_req, .wr_data, .rd_valid_q, .rd_data_q, .rd_ea_q, .rd_ptr_next_q, .psv_sel_q,
    .wr_ea_q, .wr_ptr_next_q, .wreg_we_q, .wreg_new_q, .addr_err_q);
  masd_pmem_model i_pm (.aclk(aclk), .addr(prog_addr_q), .rdata(pm_rdata));

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic masd_pkg::masd_dreq_t mk(input logic b, input masd_pkg::masd_amode_t m,
                                              input logic [15:0] p, input logic [15:0] l);
    return '{1'b1, b, m, p, l};
  endfunction : mk

  function automatic logic [15:0] exp_rd(input logic [15:0] a, input logic b);
    logic [15:0] v;
    v = (a[15] | a[14]) ? 16'h0000 : dm[a[13:1]];
    return b ? {8'h00, a[0] ? v[15:8] : v[7:0]} : v;
  endfunction : exp_rd

  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    s_awvalid <= wr;
    s_wvalid <= wr;
    s_bready <= wr;
    s_arvalid <= !wr;
    s_rready <= !wr;
    do
    begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_arready) s_arvalid <= 1'b0;
    end
    while ((wr ? s_bvalid : s_rvalid) !== 1'b1);
    rd = s_rdata;
    rsp = wr ? s_bresp : s_rresp;
    s_bready <= 1'b0;
    s_rready <= 1'b0;
  endtask : axi

  task automatic dacc(input masd_pkg::masd_dreq_t r, input masd_pkg::masd_dreq_t q,
                      input logic [15:0] d);
    @(posedge aclk);
    rd_req <= r;
    wr_req <= q;
    wr_data <= d;
    @(posedge aclk);
    rd_req <= NOQ;
    wr_req <= NOQ;
    #1;
  endtask : dacc

  // Step and load last one edge only, the source stays selected
  task automatic pdrv(input masd_pkg::masd_preq_t p);
    @(posedge aclk);
    preq <= p;
    @(posedge aclk);
    preq.step <= 1'b0;
    preq.load <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : pdrv

  task automatic rst(input logic big);
    aresetn <= 1'b0;
    mem_size_large <= big;
    repeat (6) @(posedge aclk);
    `CHK("hold", 1'b1, core_hold_q)
    aresetn <= 1'b1;
    while (core_hold_q !== 1'b0)
    begin
      @(posedge aclk);
    end
    #1;
  endtask : rst

  task automatic stop_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Scenarios
  initial
  begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, mem_size_large} = '0;
    {s_awaddr, s_araddr, s_wdata, wreg_old, psv_rdata, wr_data} = '0;
    {preq, rd_req, wr_req} = '0;
    s_wstrb = 4'hf;
    wop = masd_pkg::WOP_NONE;
    seed = 32'h0000_87ed;
    err_total = 0;
    compares = 0;
    for (int b = 0; b < 2; b++)
    begin
      rst(b[0]);
      `CHK("pc0", 24'h00_0000, prog_addr_q)
      for (int i = 0; i < 4; i++)
      begin
        axi(1'b0, masd_pkg::OFS_CFG0 + 8'(4 * i), 32'h0);
        w = b ? 16'habf8 : 16'h57f8;
        `CHK("cfg", {8'h00, i_pm.word_at({8'h00, w + 16'(2 * i)})}, rd)
      end
      axi(1'b0, masd_pkg::OFS_STAT, 32'h0);
      `CHK("stat", {b[0], 3'b001}, rd[3:0])
    end
    axi(1'b0, 8'h40, 32'h0);
    `CHK("unm", {masd_pkg::RESP_SLVERR, 32'h0}, {rsp, rd})
    axi(1'b1, masd_pkg::OFS_CTRL, 32'h4);
    axi(1'b0, masd_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h4, rd)
    for (int i = 0; i < 5; i++)
    begin
      pq = '0;
      pq.load = 1'b1;
      pq.target = tg[i];
      pdrv(pq);
      `CHK("pa", {1'b0, tg[i][22:1], 1'b0}, prog_addr_q)
      `CHK("rg", rg[i], prog_region_q)
    end
    pq = '0;
    pq.step = 1'b1;
    pdrv(pq);
    `CHK("inc", 24'h00_0202, prog_addr_q)
    pq.dec = 1'b1;
    pdrv(pq);
    `CHK("dec", 24'h00_0200, prog_addr_q)
    axi(1'b1, masd_pkg::OFS_TABLE_PAGE_REGISTER, 32'h80);
    pq = '0;
    pq.src = masd_pkg::PS_TABLE;
    pq.tbl_off = 16'h0006;
    pdrv(pq);
    `CHK("tbl", 25'h080_0006, {prog_fault_q, prog_addr_q})
    pq.src = masd_pkg::PS_REMAP;
    pq.remap_addr = 24'h81_2346;
    pdrv(pq);
    `CHK("rmp", 25'h101_2346, {prog_fault_q, prog_addr_q})
    preq <= '0;
    // Random word write, odd lane byte write, random read
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      ea = {2'b00, seed[13:1], 1'b0};
      dacc(NOQ, mk(1'b0, masd_pkg::AM_IND, ea, 16'h0), seed[31:16]);
      dm[ea[13:1]] = seed[31:16];
      `CHK("wea", ea, wr_ea_q)
      dacc(NOQ, mk(1'b1, masd_pkg::AM_IND, ea | 16'h1, 16'h0), {8'h00, seed[7:0]});
      dm[ea[13:1]][15:8] = seed[7:0];
      dacc(mk(seed[14], masd_pkg::AM_IND, ea | 16'(seed[15]), 16'h0), NOQ, 16'h0);
      `CHK("rd", {1'b1, exp_rd(ea | 16'(seed[15]), seed[14])}, {rd_valid_q, rd_data_q})
      `CHK("ae", ~seed[14] & seed[15], addr_err_q)
    end
    dacc(NOQ, mk(1'b0, masd_pkg::AM_IND, ea | 16'h1, 16'h0), 16'hdead);
    `CHK("wae", 1'b1, addr_err_q)
    dacc(mk(1'b0, masd_pkg::AM_IND, ea, 16'h0), NOQ, 16'h0);
    `CHK("wsup", dm[ea[13:1]], rd_data_q)
    dacc(mk(1'b1, masd_pkg::AM_POSTINC, 16'h0100, 16'h0),
         mk(1'b0, masd_pkg::AM_POSTINC, 16'h0200, 16'h0), 16'h0);
    `CHK("pib", 32'h0101_0202, {rd_ptr_next_q, wr_ptr_next_q})
    dm[256] = 16'h0000;
    dacc(mk(1'b0, masd_pkg::AM_NEAR, 16'h0, 16'hfffe), NOQ, 16'h0);
    `CHK("near", 16'h1ffe, rd_ea_q)
    dacc(mk(1'b0, masd_pkg::AM_FULL, 16'h0, 16'h4002), NOQ, 16'h0);
    `CHK("full", 32'h4002_0000, {rd_ea_q, rd_data_q})
    psv_rdata <= 16'hbeef;
    for (int k = 0; k < 2; k++)
    begin
      dacc(mk(1'b0, masd_pkg::AM_FULL, 16'h0, 16'h8000), NOQ, 16'h0);
      `CHK("psv", k ? 17'h0_0000 : 17'h1_beef, {psv_sel_q, rd_data_q})
      axi(1'b1, masd_pkg::OFS_CTRL, 32'h0);
    end
    wreg_old <= 16'h3480;
    for (int k = 1; k < 5; k++)
    begin
      wop <= masd_pkg::masd_wop_t'(k);
      dacc(mk(k != 2, masd_pkg::AM_IND, ea, 16'h0), NOQ, 16'h0);
      w = (k == 1) ? {8'h34, dm[ea[13:1]][7:0]} : (k == 2) ? dm[ea[13:1]] :
          (k == 3) ? 16'hff80 : 16'h0080;
      `CHK("wreg", {1'b1, w}, {wreg_we_q, wreg_new_q})
    end
    wop <= masd_pkg::WOP_NONE;
    axi(1'b0, masd_pkg::OFS_STAT, 32'h0);
    `CHK("stk", 2'b11, rd[2:1])
    axi(1'b1, masd_pkg::OFS_STAT, 32'h6);
    axi(1'b0, masd_pkg::OFS_STAT, 32'h0);
    `CHK("w1c", 2'b00, rd[2:1])
    stop_test();
  end

  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    stop_test();
  end
endmodule : tb_memory_address_space_decoder
